// file: pkg/rsr_defines.vh
`ifndef RSR_DEFINES_VH
`define RSR_DEFINES_VH

// register offsets
`define RSR_REG_CTRL 4'h0
`define RSR_REG_STAT 4'h4
`define RSR_REG_INFO 4'h8
`define RSR_REG_CNT 4'hC

// control fields
`define RSR_CTRL_EOM 0
`define RSR_CTRL_CLR 1
`define RSR_CTRL_RST 1'b0

// link phase codes
`define RSR_PH_FREE 3'h0
`define RSR_PH_DIN 3'h1
`define RSR_PH_STAT 3'h3
`define RSR_PH_MSGI 3'h7

// status and message bytes
`define RSR_STATUS_GOOD 8'h00
`define RSR_MSG_CMD_CPL 8'h00

// sense record layout
`define RSR_SENSE_LEN 5'h12
`define RSR_SENSE_B0 8'hF0
`define RSR_SENSE_ADD_LEN 8'h0A
`define RSR_IDX_KEY 5'h02
`define RSR_IDX_INFO0 5'h03
`define RSR_IDX_INFO3 5'h06
`define RSR_IDX_ADDLEN 5'h07
`define RSR_IDX_ASC 5'h0C
`define RSR_IDX_ASCQ 5'h0D

// sense keys
`define RSR_KEY_NONE 4'h0
`define RSR_KEY_NRDY 4'h2
`define RSR_KEY_MED 4'h3
`define RSR_KEY_HW 4'h4
`define RSR_KEY_ILL 4'h5
`define RSR_KEY_UA 4'h6
`define RSR_KEY_ABRT 4'hB

// additional sense codes
`define RSR_ASC_NONE 8'h00
`define RSR_ASC_INTERNAL 8'h44
`define RSR_ASC_MSG_ERR 8'h43

`endif

// file: rtl/rsr_responder.v
// Operation
// - on command, snapshot condition and send it
// - then GOOD status, command complete, release busy
// - allocation length zero sends nothing, no error
// - stop at allocation length or record end
// - record built on check condition or bus-free error
// - valid bit always one
// - error code always current error
// - segment number always zero
// - file mark always zero
// - end-of-medium shows window reading complete
// - length flag set on block length mismatch
// - only keys 0,2,3,4,5,6,B reported
// - key 0 on success or length-only check
// - key 2 when unit not accessible
// - key 3 on medium problem
// - key 4 on unrecoverable hardware fault
// - key 5 on illegal command or parameters
// - key 6 after target reset
// - key B when command aborted
// - info bytes hold requested minus actual count
// - additional length always ten
// - bytes C and D carry code, qualifier
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "rsr_defines.vh"

module rsr_responder (
    // clock and reset
    input wire clk,
    input wire resetn,
    // register port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // decoded request sense command
    input wire cmd_valid,
    input wire [7:0] cmd_alloc,
    input wire cmd_lun_ok,
    // error reports from the scanner
    input wire err_valid,
    input wire [3:0] err_key,
    input wire [7:0] err_asc,
    input wire [7:0] err_ascq,
    input wire err_ili,
    input wire [31:0] err_info,
    input wire busfree_err,
    // target side of the link
    output reg bsy,
    output reg [2:0] phase,
    output reg req,
    output reg [7:0] data_out,
    input wire ack
);

    ////////////////////////////////////////////////////////////////////
    // states, one-hot

    localparam [5:0] ST_IDLE = 6'b000001;
    localparam [5:0] ST_LOAD = 6'b000010;
    localparam [5:0] ST_DATA = 6'b000100;
    localparam [5:0] ST_STAT = 6'b001000;
    localparam [5:0] ST_MSG = 6'b010000;
    localparam [5:0] ST_FREE = 6'b100000;

    reg [5:0] state_q;
    reg [4:0] count_q;
    reg [4:0] send_n_q;

    // stored condition
    reg pend_q;
    reg [3:0] key_q;
    reg [7:0] asc_q;
    reg [7:0] ascq_q;
    reg ili_q;
    reg [31:0] info_q;
    // stored record must outlive the current sequence
    reg hold_q;

    // snapshot sent on the link
    reg [3:0] s_key_q;
    reg [7:0] s_asc_q;
    reg [7:0] s_ascq_q;
    reg s_ili_q;
    reg [31:0] s_info_q;
    reg s_eom_q;

    // software control
    reg eom_q;
    reg clr_q;

    wire [7:0] sbyte;
    wire take;
    wire key_ok;
    wire new_err;
    wire delivered;

    ////////////////////////////////////////////////////////////////////
    // key screening

    function legal_key;
        input [3:0] k;
        begin
            legal_key = (k == `RSR_KEY_NONE) || (k == `RSR_KEY_NRDY) ||
                        (k == `RSR_KEY_MED) || (k == `RSR_KEY_HW) ||
                        (k == `RSR_KEY_ILL) || (k == `RSR_KEY_UA) ||
                        (k == `RSR_KEY_ABRT);
        end
    endfunction

    assign key_ok = legal_key(err_key);
    assign new_err = err_valid | busfree_err;
    // byte taken on the edge where both are high
    assign take = req & ack;
    // stored record went out in this sequence
    assign delivered = state_q[5] & pend_q & ~hold_q;

    ////////////////////////////////////////////////////////////////////
    // stored sense condition

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            // reset itself is reported as unit attention
            pend_q <= 1'b1;
            key_q <= `RSR_KEY_UA;
            asc_q <= `RSR_ASC_NONE;
            ascq_q <= 8'h00;
            ili_q <= 1'b0;
            info_q <= 32'h0000_0000;
        end else if (busfree_err) begin
            // a bus-free error overrides any report of the same cycle
            pend_q <= 1'b1;
            key_q <= `RSR_KEY_ABRT;
            asc_q <= `RSR_ASC_MSG_ERR;
            ascq_q <= 8'h00;
            ili_q <= 1'b0;
            info_q <= 32'h0000_0000;
        end else if (err_valid) begin
            pend_q <= 1'b1;
            if (key_ok) begin
                // covers keys 0,2,3,4,5,6,B as reported
                key_q <= err_key;
                asc_q <= err_asc;
                ascq_q <= err_ascq;
            end else begin
                // unknown key folds into internal hardware fault
                key_q <= `RSR_KEY_HW;
                asc_q <= `RSR_ASC_INTERNAL;
                ascq_q <= 8'h00;
            end
            ili_q <= err_ili;
            info_q <= err_info;
        end else if (delivered || clr_q) begin
            // new error above wins over this clear
            pend_q <= 1'b0;
            key_q <= `RSR_KEY_NONE;
            asc_q <= `RSR_ASC_NONE;
            ascq_q <= 8'h00;
            ili_q <= 1'b0;
            info_q <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // delivery tracking

    // the snapshot is frozen in load, so an error stored from that edge
    // on, or a record replaced by the unit check, never went out
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hold_q <= 1'b0;
        end else if (new_err) begin
            // kept for the next request rather than lost at free
            hold_q <= ~state_q[0];
        end else if (state_q[0]) begin
            hold_q <= 1'b0;
        end else if (state_q[1] && !cmd_lun_ok) begin
            hold_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // command sequencer

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
            count_q <= 5'h00;
            send_n_q <= 5'h00;
            s_key_q <= `RSR_KEY_NONE;
            s_asc_q <= `RSR_ASC_NONE;
            s_ascq_q <= 8'h00;
            s_ili_q <= 1'b0;
            s_info_q <= 32'h0000_0000;
            s_eom_q <= 1'b0;
            bsy <= 1'b0;
            phase <= `RSR_PH_FREE;
            req <= 1'b0;
            data_out <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        // truncate to the shorter of allocation and record
                        if (cmd_alloc > {3'b000, `RSR_SENSE_LEN}) begin
                            send_n_q <= `RSR_SENSE_LEN;
                        end else begin
                            send_n_q <= cmd_alloc[4:0];
                        end
                        bsy <= 1'b1;
                        state_q <= ST_LOAD;
                    end
                end
                ST_LOAD: begin
                    // freeze condition so late errors cannot tear the record
                    if (!cmd_lun_ok) begin
                        s_key_q <= `RSR_KEY_NRDY;
                        s_asc_q <= `RSR_ASC_NONE;
                        s_ascq_q <= 8'h00;
                        s_ili_q <= 1'b0;
                        s_info_q <= 32'h0000_0000;
                    end else begin
                        s_key_q <= key_q;
                        s_asc_q <= asc_q;
                        s_ascq_q <= ascq_q;
                        s_ili_q <= ili_q;
                        s_info_q <= info_q;
                    end
                    s_eom_q <= eom_q;
                    count_q <= 5'h00;
                    if (send_n_q == 5'h00) begin
                        // zero allocation goes straight to status
                        phase <= `RSR_PH_STAT;
                        state_q <= ST_STAT;
                    end else begin
                        phase <= `RSR_PH_DIN;
                        state_q <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    if (!req) begin
                        data_out <= sbyte;
                        req <= 1'b1;
                    end else if (take) begin
                        req <= 1'b0;
                        count_q <= count_q + 5'h01;
                        if (count_q + 5'h01 == send_n_q) begin
                            phase <= `RSR_PH_STAT;
                            state_q <= ST_STAT;
                        end
                    end
                end
                ST_STAT: begin
                    if (!req) begin
                        data_out <= `RSR_STATUS_GOOD;
                        req <= 1'b1;
                    end else if (take) begin
                        req <= 1'b0;
                        phase <= `RSR_PH_MSGI;
                        state_q <= ST_MSG;
                    end
                end
                ST_MSG: begin
                    if (!req) begin
                        data_out <= `RSR_MSG_CMD_CPL;
                        req <= 1'b1;
                    end else if (take) begin
                        req <= 1'b0;
                        state_q <= ST_FREE;
                    end
                end
                ST_FREE: begin
                    // stored record drops on this edge unless held
                    bsy <= 1'b0;
                    phase <= `RSR_PH_FREE;
                    data_out <= 8'h00;
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                    bsy <= 1'b0;
                    req <= 1'b0;
                    phase <= `RSR_PH_FREE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // sense record bytes

    rsr_sense_byte u_sbyte (
        .idx(count_q),
        .key(s_key_q),
        .asc(s_asc_q),
        .ascq(s_ascq_q),
        .ili(s_ili_q),
        .eom(s_eom_q),
        .info(s_info_q),
        .sbyte(sbyte)
    );

    ////////////////////////////////////////////////////////////////////
    // register port

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            eom_q <= `RSR_CTRL_RST;
            clr_q <= 1'b0;
        end else begin
            clr_q <= 1'b0;
            if (reg_wr && reg_addr == `RSR_REG_CTRL) begin
                eom_q <= reg_wdata[`RSR_CTRL_EOM];
                clr_q <= reg_wdata[`RSR_CTRL_CLR];
            end
        end
    end

    // read data stands in the cycle after the strobe only
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 32'h0000_0000;
        end else if (!reg_rd) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_addr == `RSR_REG_CTRL) begin
            reg_rdata <= {31'h0000_0000, eom_q};
        end else if (reg_addr == `RSR_REG_STAT) begin
            reg_rdata <= {ascq_q, asc_q, key_q, 3'b000, pend_q, 2'b00, state_q};
        end else if (reg_addr == `RSR_REG_INFO) begin
            reg_rdata <= info_q;
        end else if (reg_addr == `RSR_REG_CNT) begin
            reg_rdata <= {19'h0_0000, send_n_q, 3'b000, count_q};
        end else begin
            reg_rdata <= 32'h0000_0000;
        end
    end

endmodule // rsr_responder

// file: rtl/rsr_sense_byte.v
`timescale 1ns/1ps
`include "rsr_defines.vh"

module rsr_sense_byte (
    // byte select
    input wire [4:0] idx,
    // captured condition
    input wire [3:0] key,
    input wire [7:0] asc,
    input wire [7:0] ascq,
    input wire ili,
    input wire eom,
    input wire [31:0] info,
    // selected byte
    output reg [7:0] sbyte
);

    wire [31:0] info_eff;
    wire [4:0] info_sel;

    // info only carries meaning with the length flag
    assign info_eff = ili ? info : 32'h0000_0000;
    assign info_sel = `RSR_IDX_INFO3 - idx;

    always @* begin
        sbyte = 8'h00;
        if (idx == 5'h00) begin
            sbyte = `RSR_SENSE_B0;
        end else if (idx == `RSR_IDX_KEY) begin
            sbyte = {1'b0, eom, ili, 1'b0, key};
        end else if (idx >= `RSR_IDX_INFO0 && idx <= `RSR_IDX_INFO3) begin
            sbyte = info_eff[{info_sel[1:0], 3'b000} +: 8];
        end else if (idx == `RSR_IDX_ADDLEN) begin
            sbyte = `RSR_SENSE_ADD_LEN;
        end else if (idx == `RSR_IDX_ASC) begin
            sbyte = asc;
        end else if (idx == `RSR_IDX_ASCQ) begin
            sbyte = ascq;
        end
    end

endmodule // rsr_sense_byte

// file: tb/rsr_host_model.sv
`timescale 1ns/1ps
module rsr_host_model (
    // clock and reset
    input wire clk,
    input wire resetn,
    // target side
    input wire req,
    input wire [2:0] phase,
    input wire [7:0] data_out,
    output reg ack,
    // bench control
    input wire [3:0] dly,
    input wire clr
);
    reg [7:0] got_byte [0:31];
    reg [2:0] got_ph [0:31];
    reg [5:0] got_n;
    reg [3:0] wait_q;
    // ack is a one-cycle pulse; a slow host waits dly cycles first
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
            wait_q <= 4'h0;
            got_n <= 6'h00;
        end else begin
            if (clr)
                got_n <= 6'h00;
            if (ack || !req) begin
                ack <= 1'b0;
                wait_q <= 4'h0;
            end else if (wait_q >= dly) begin
                ack <= 1'b1;
                got_byte[got_n[4:0]] <= data_out;
                got_ph[got_n[4:0]] <= phase;
                got_n <= got_n + 6'h01;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule // rsr_host_model

// file: tb/rsr_responder_asserts.sv
`timescale 1ns/1ps
module rsr_responder_asserts (
    // clock and reset
    input wire clk,
    input wire resetn,
    // command and link
    input wire cmd_valid,
    input wire [7:0] cmd_alloc,
    input wire bsy,
    input wire [2:0] phase,
    input wire req,
    input wire [7:0] data_out,
    input wire ack
);
    reg [7:0] alloc_q;
    reg [4:0] cnt_q;
    wire [7:0] lim = (alloc_q < 8'h12) ? alloc_q : 8'h12;
    // counts sense bytes taken by the host in the current command
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            alloc_q <= 8'h00;
            cnt_q <= 5'h00;
        end else if (cmd_valid && !bsy) begin
            alloc_q <= cmd_alloc;
            cnt_q <= 5'h00;
        end else if (req && ack && phase == 3'h1) begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    cmd_busy_a: assert property (cmd_valid && !bsy |=> bsy)
        else $error("busy not raised after command");
    data_phase_a: assert property (cmd_valid && !bsy && cmd_alloc != 8'h00 |=> ##1 phase == 3'h1)
        else $error("data in phase missing");
    zero_alloc_a: assert property (cmd_valid && !bsy && cmd_alloc == 8'h00 |=> ##1 phase == 3'h3)
        else $error("zero length did not skip data");
    req_hold_a: assert property (req && !ack |=> req && $stable(data_out) && $stable(phase))
        else $error("byte dropped before ack");
    sense_count_a: assert property (phase == 3'h3 && req |-> cnt_q == lim[4:0])
        else $error("wrong sense byte count");
    first_byte_a: assert property (phase == 3'h1 && req && cnt_q == 5'h00 |-> data_out == 8'hF0)
        else $error("sense byte 0 wrong");
    segment_zero_a: assert property (phase == 3'h1 && req && cnt_q == 5'h01 |-> data_out == 8'h00)
        else $error("segment byte not zero");
    fm_zero_a: assert property (phase == 3'h1 && req && cnt_q == 5'h02 |-> !data_out[7])
        else $error("file mark set");
    add_len_a: assert property (phase == 3'h1 && req && cnt_q == 5'h07 |-> data_out == 8'h0A)
        else $error("additional length wrong");
    status_good_a: assert property (phase == 3'h3 && req |-> data_out == 8'h00)
        else $error("status not good");
    msg_free_a: assert property (phase == 3'h7 && req && ack |-> ##2 (!bsy && phase == 3'h0))
        else $error("bus not freed after message");
endmodule // rsr_responder_asserts

bind rsr_responder rsr_responder_asserts rsr_responder_asserts_i (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid), .cmd_alloc(cmd_alloc), .bsy(bsy),
    .phase(phase), .req(req), .data_out(data_out), .ack(ack));

// file: tb/rsr_responder_tb_top.sv
`timescale 1ns/1ps
module rsr_responder_tb_top;
    reg clk, resetn, reg_wr, reg_rd, cmd_valid, cmd_lun_ok, err_valid, err_ili, busfree_err, clr;
    reg [3:0] reg_addr, err_key, dly, ek;
    reg [31:0] reg_wdata, err_info, einfo;
    reg [7:0] cmd_alloc, err_asc, err_ascq, ea, eq;
    reg [19:0] sv;
    reg eili, eeom;
    reg [15:0] rnd;
    reg [3:0] keys [0:6];
    wire [31:0] reg_rdata;
    wire bsy, req, ack;
    wire [2:0] phase;
    wire [7:0] data_out;
    integer num_errors, tests_run, i, j, n;

    rsr_responder rsr_responder_i (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmd_valid(cmd_valid), .cmd_alloc(cmd_alloc), .cmd_lun_ok(cmd_lun_ok),
        .err_valid(err_valid), .err_key(err_key), .err_asc(err_asc), .err_ascq(err_ascq),
        .err_ili(err_ili), .err_info(err_info), .busfree_err(busfree_err), .bsy(bsy),
        .phase(phase), .req(req), .data_out(data_out), .ack(ack));
    rsr_host_model rsr_host_model_i (.clk(clk), .resetn(resetn), .req(req), .phase(phase),
        .data_out(data_out), .ack(ack), .dly(dly), .clr(clr));

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////
    function [15:0] lfsr(input [15:0] x);
        lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function [7:0] exp_byte(input [4:0] k);
        case (k)
            5'h00: exp_byte = 8'hF0;
            5'h02: exp_byte = {1'b0, eeom, eili, 1'b0, ek};
            5'h03: exp_byte = eili ? einfo[31:24] : 8'h00;
            5'h04: exp_byte = eili ? einfo[23:16] : 8'h00;
            5'h05: exp_byte = eili ? einfo[15:8] : 8'h00;
            5'h06: exp_byte = eili ? einfo[7:0] : 8'h00;
            5'h07: exp_byte = 8'h0A;
            5'h0C: exp_byte = ea;
            5'h0D: exp_byte = eq;
            default: exp_byte = 8'h00;
        endcase
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            tests_run = tests_run + 1;
            if (got !== exp) begin
                num_errors = num_errors + 1;
                $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task test_done;
        begin
            $display("errors=%0d checks=%0d", num_errors, tests_run);
            if (num_errors == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task wr(input [3:0] a, input [31:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= d;
            reg_wr <= 1'b1;
            @(posedge clk);
            reg_wr <= 1'b0;
        end
    endtask
    task rd(input [3:0] a, input [31:0] exp);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge clk);
            reg_rd <= 1'b0;
            #1;
            chk(reg_rdata, exp);
            @(posedge clk);
        end
    endtask
    task inj(input [3:0] k, input il);
        begin
            rnd = lfsr(rnd);
            {ek, ea, eq, eili, einfo} = {k, rnd, il, rnd, ~rnd};
            {err_key, err_asc, err_ascq, err_ili, err_info} <= {k, rnd, il, rnd, ~rnd};
            err_valid <= 1'b1;
            @(posedge clk);
            err_valid <= 1'b0;
        end
    endtask
    // one request sense; compares the host's byte count, sense bytes 0 to 13, then status and message
    task rs(input [7:0] al, input lun);
        begin
            rnd = lfsr(rnd);
            dly <= {1'b0, rnd[2:0]};
            {clr, cmd_valid, cmd_alloc, cmd_lun_ok} <= {2'b11, al, lun};
            @(posedge clk);
            {clr, cmd_valid} <= 2'b00;
            n = 0;
            while (n < 1000 && (n < 3 || bsy)) begin
                @(posedge clk);
                n = n + 1;
            end
            if (n >= 1000) begin
                num_errors = num_errors + 1;
                test_done;
            end
            n = (al < 8'h12) ? al : 18;
            chk(rsr_host_model_i.got_n, n + 2);
            for (i = 0; i < n && i < 14; i = i + 1)
                chk({rsr_host_model_i.got_ph[i], rsr_host_model_i.got_byte[i]}, {3'h1, exp_byte(i)});
            chk({rsr_host_model_i.got_ph[n], rsr_host_model_i.got_byte[n],
                rsr_host_model_i.got_ph[n + 1], rsr_host_model_i.got_byte[n + 1]}, 22'h180700);
            if (lun)
                {ek, ea, eq, eili} = 21'h0;
            @(posedge clk);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        keys = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'hB};
        {reg_wr, reg_rd, cmd_valid, err_valid, err_ili, busfree_err, clr, cmd_lun_ok} = 8'h01;
        {reg_addr, reg_wdata, cmd_alloc, err_key, err_asc, err_ascq, err_info, dly} = 0;
        {num_errors, tests_run, rnd, resetn} = {64'h0, 16'd45688, 1'b0};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        rd(4'h4, 32'h0000_6101);
        rd(4'h2, 32'h0);
        {ek, ea, eq, eili, einfo, eeom} = {4'h6, 50'h0};
        rs(8'h12, 1'b1);
        rs(8'h12, 1'b1);
        wr(4'h0, 32'h1);
        eeom = 1'b1;
        rd(4'h0, 32'h1);
        inj(4'h3, 1'b1);
        rd(4'h8, einfo);
        rs(8'hFF, 1'b1);
        wr(4'h0, 32'h0);
        eeom = 1'b0;
        inj(4'h5, 1'b0);
        rs(8'h00, 1'b1);
        rs(8'h01, 1'b1);
        inj(4'h5, 1'b0);
        sv = {ek, ea, eq};
        {ek, ea, eq} = {4'h2, 16'h0};
        rs(8'h12, 1'b0);
        {ek, ea, eq} = sv;
        rd(4'h4, {eq, ea, ek, 12'h101});
        rs(8'h12, 1'b1);
        busfree_err <= 1'b1;
        @(posedge clk);
        busfree_err <= 1'b0;
        {ek, ea, eq} = {4'hB, 16'h4300};
        rs(8'h0E, 1'b1);
        rd(4'hC, 32'h0000_0E0E);
        inj(4'h4, 1'b0);
        wr(4'h0, 32'h2);
        {ek, ea, eq} = 20'h0;
        rs(8'h12, 1'b1);
        for (j = 0; j < 7; j = j + 1) begin
            inj(keys[j], rnd[3]);
            rs({3'h0, rnd[12:8]}, 1'b1);
        end
        inj(4'h7, 1'b0);
        {ek, ea, eq} = {4'h4, 16'h4400};
        rs(8'h12, 1'b1);
        test_done;
    end
endmodule // rsr_responder_tb_top
